// ==== rcai_top.sv ====
// Overview of operation
// - unused bits ignore writes and read back as zero
// - all time digits are kept and counted as bcd
// - busy is high while an increment cycle runs and whenever the freeze bit is zero
// - counter accesses during busy are inhibited by the device
// - busy reads one whenever the freeze bit is zero
// - control registers are accessible at any time without busy check
// - counter bits are positive logic on the data lines
//
// The AHB-Lite register port and the register offsets were decided locally.
module rcai_top #(
	parameter int unsigned TICK_CYCLES = rcai_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// status
	output logic             counter_busy
);

	logic [rcai_pkg::NUM_CNT_REGS-1:0][3:0] cnt_q;
	logic                                   hold_q;
	logic [3:0]                             ctl_e_q;
	logic [3:0]                             ctl_f_q;
	rcai_pkg::rcai_inc_e                    inc_state_q;
	logic [rcai_pkg::INC_CNT_W-1:0]         inc_cnt_q;
	logic                                   pend_q;
	rcai_pkg::rcai_acc_s                    acc_q;
	logic [31:0]                            hrdata_q;

	logic                                   tick;
	logic                                   busy_stat;
	logic                                   inc_apply;
	logic                                   addr_take;
	logic                                   addr_mapped;
	logic [3:0]                             addr_idx;
	logic                                   wr_take;
	logic [3:0]                             wr_nib;
	rcai_pkg::rcai_bcd_s                    pair_cur [rcai_pkg::NUM_PAIRS];
	rcai_pkg::rcai_bcd_s                    pair_lo  [rcai_pkg::NUM_PAIRS];
	rcai_pkg::rcai_bcd_s                    pair_hi  [rcai_pkg::NUM_PAIRS];
	rcai_pkg::rcai_bcd_s                    pair_nxt [rcai_pkg::NUM_PAIRS];
	logic [rcai_pkg::NUM_PAIRS-1:0]         pair_wrap;
	logic [rcai_pkg::NUM_PAIRS:0]           pair_en;
	logic [3:0]                             wday_nxt;

	// used bits of each register
	function automatic logic [3:0] reg_mask(input logic [3:0] idx);
		case (idx)
			rcai_pkg::REG_SEC_TENS,
			rcai_pkg::REG_MIN_TENS,
			rcai_pkg::REG_HOUR_TENS,
			rcai_pkg::REG_WEEKDAY:    reg_mask = rcai_pkg::MASK_3BIT;
			rcai_pkg::REG_DAY_TENS:   reg_mask = rcai_pkg::MASK_2BIT;
			rcai_pkg::REG_MONTH_TENS: reg_mask = rcai_pkg::MASK_1BIT;
			rcai_pkg::REG_FIRST_CTL:  reg_mask = rcai_pkg::MASK_FIRST;
			default:                  reg_mask = rcai_pkg::MASK_FULL;
		endcase
	endfunction

	function automatic logic is_counter(input logic [3:0] idx);
		is_counter = (idx <= rcai_pkg::REG_WEEKDAY);
	endfunction

	// last day of a month, leap years every fourth year
	function automatic rcai_pkg::rcai_bcd_s month_end(input rcai_pkg::rcai_bcd_s mon,
			input rcai_pkg::rcai_bcd_s yr);
		logic leap;
		leap = yr.tens[0] ? (yr.units == 4'h2 || yr.units == 4'h6)
		                  : (yr.units == 4'h0 || yr.units == 4'h4 || yr.units == 4'h8);
		case (mon)
			8'h02:   month_end = leap ? rcai_pkg::BCD_29 : rcai_pkg::BCD_28;
			8'h04,
			8'h06,
			8'h09,
			8'h11:   month_end = rcai_pkg::BCD_30;
			default: month_end = rcai_pkg::BCD_31;
		endcase
	endfunction

	rcai_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.stop    (ctl_f_q[rcai_pkg::THIRD_STOP_BIT]),
		.clear   (ctl_f_q[rcai_pkg::THIRD_RESET_BIT]),
		.tick    (tick)
	);

	assign busy_stat    = (inc_state_q == rcai_pkg::INC_RUN) || !hold_q;
	assign counter_busy = busy_stat;

	// ---------------- bus slave ----------------
	assign addr_take   = hsel && hready && (htrans == rcai_pkg::HTRANS_NONSEQ);
	assign addr_mapped = (haddr[31:rcai_pkg::ADDR_IDX_MSB+1] == '0) && (haddr[1:0] == 2'b00);
	assign addr_idx    = haddr[rcai_pkg::ADDR_IDX_MSB:rcai_pkg::ADDR_IDX_LSB];

	// zero wait states; every transfer ends OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			acc_q <= '0;
		end else if (hready) begin
			acc_q.valid  <= addr_take;
			acc_q.write  <= hwrite;
			acc_q.mapped <= addr_mapped;
			acc_q.idx    <= addr_idx;
		end
	end

	// read data are fetched in the address phase and stand through the data phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hrdata_q <= rcai_pkg::RDATA_ZERO;
		end else if (hready) begin
			hrdata_q <= rcai_pkg::RDATA_ZERO;
			if (addr_take && !hwrite && addr_mapped) begin
				case (addr_idx)
					rcai_pkg::REG_FIRST_CTL: begin
						hrdata_q[rcai_pkg::FIRST_HOLD_BIT] <= hold_q;
						hrdata_q[rcai_pkg::FIRST_BUSY_BIT] <= busy_stat;
					end
					rcai_pkg::REG_SECOND_CTL: begin
						hrdata_q[3:0] <= ctl_e_q;
					end
					rcai_pkg::REG_THIRD_CTL: begin
						hrdata_q[3:0] <= ctl_f_q;
					end
					default: begin
						if (!busy_stat) begin
							hrdata_q[3:0] <= cnt_q[addr_idx] & reg_mask(addr_idx);
						end
					end
				endcase
			end
		end
	end

	assign wr_take = acc_q.valid && acc_q.write && acc_q.mapped;
	assign wr_nib  = hwdata[3:0] & reg_mask(acc_q.idx);

	// ---------------- control registers ----------------
	// control writes always taken
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			hold_q <= rcai_pkg::RST_NIBBLE[0];
		end else if (wr_take && acc_q.idx == rcai_pkg::REG_FIRST_CTL) begin
			hold_q <= wr_nib[rcai_pkg::FIRST_HOLD_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctl_e_q <= rcai_pkg::RST_NIBBLE;
		end else if (wr_take && acc_q.idx == rcai_pkg::REG_SECOND_CTL) begin
			ctl_e_q <= wr_nib;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctl_f_q <= rcai_pkg::RST_NIBBLE;
		end else if (wr_take && acc_q.idx == rcai_pkg::REG_THIRD_CTL) begin
			ctl_f_q <= wr_nib;
		end
	end

	// ---------------- increment sequencing ----------------
	// one pending second is kept while frozen; further ones are lost
	always_ff @(posedge sys_clk) begin
		if (sys_rst || ctl_f_q[rcai_pkg::THIRD_RESET_BIT]) begin
			pend_q <= 1'b0;
		end else if (tick) begin
			pend_q <= 1'b1;
		end else if (inc_state_q == rcai_pkg::INC_IDLE && !hold_q) begin
			pend_q <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			inc_state_q <= rcai_pkg::INC_IDLE;
			inc_cnt_q   <= '0;
		end else begin
			case (inc_state_q)
				rcai_pkg::INC_IDLE: begin
					inc_cnt_q <= '0;
					if (pend_q && !hold_q) begin
						inc_state_q <= rcai_pkg::INC_RUN;
					end
				end
				rcai_pkg::INC_RUN: begin
					inc_cnt_q <= inc_cnt_q + rcai_pkg::INC_CNT_W'(1);
					if (inc_apply) begin
						inc_state_q <= rcai_pkg::INC_IDLE;
					end
				end
				default: begin
					inc_state_q <= rcai_pkg::INC_IDLE;
				end
			endcase
		end
	end

	assign inc_apply = (inc_state_q == rcai_pkg::INC_RUN)
	                && (inc_cnt_q == rcai_pkg::INC_CNT_W'(rcai_pkg::INC_CYCLES - 1));

	// ---------------- bcd carry chain ----------------
	always_comb begin
		pair_lo[0] = rcai_pkg::BCD_00;
		pair_hi[0] = rcai_pkg::BCD_59;
		pair_lo[1] = rcai_pkg::BCD_00;
		pair_hi[1] = rcai_pkg::BCD_59;
		pair_lo[2] = rcai_pkg::BCD_00;
		pair_hi[2] = rcai_pkg::BCD_23;
		pair_lo[3] = rcai_pkg::BCD_01;
		pair_hi[3] = month_end(pair_cur[4], pair_cur[5]);
		pair_lo[4] = rcai_pkg::BCD_01;
		pair_hi[4] = rcai_pkg::BCD_12;
		pair_lo[5] = rcai_pkg::BCD_00;
		pair_hi[5] = rcai_pkg::BCD_99;
	end

	assign pair_en[0] = inc_apply;

	genvar gp;
	generate
		for (gp = 0; gp < rcai_pkg::NUM_PAIRS; gp++) begin : g_pair
			assign pair_cur[gp] = {cnt_q[2*gp+1], cnt_q[2*gp]};
			rcai_bcd_pair u_pair (
				.cur  (pair_cur[gp]),
				.lo   (pair_lo[gp]),
				.hi   (pair_hi[gp]),
				.nxt  (pair_nxt[gp]),
				.wrap (pair_wrap[gp])
			);
			assign pair_en[gp+1] = pair_en[gp] && pair_wrap[gp];
		end
	endgenerate

	assign wday_nxt = (cnt_q[rcai_pkg::REG_WEEKDAY] >= rcai_pkg::WEEKDAY_MAX)
	                ? 4'h0 : cnt_q[rcai_pkg::REG_WEEKDAY] + 4'h1;

	// ---------------- counter storage ----------------
	// host writes only land while frozen and idle, so they never meet an increment
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			for (int p = 0; p < rcai_pkg::NUM_PAIRS; p++) begin
				if (pair_en[p]) begin
					{cnt_q[2*p+1], cnt_q[2*p]} <= pair_nxt[p];
				end
			end
			// weekday advances with the day carry out of hours
			if (pair_en[3]) begin
				cnt_q[rcai_pkg::REG_WEEKDAY] <= wday_nxt;
			end
			if (wr_take && is_counter(acc_q.idx) && !busy_stat) begin
				cnt_q[acc_q.idx] <= wr_nib;
			end
		end
	end

	logic unused_ok;
	assign unused_ok = ^hsize;

endmodule // rcai_top

// ==== rcai_pkg.sv ====
package rcai_pkg;

	// clock and timing
	localparam int unsigned CLK_PERIOD_NS   = 5;
	localparam int unsigned TICK_PERIOD_NS  = 1_000_000_000;
	localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned INC_TIME_NS     = 100;
	localparam int unsigned INC_CYCLES      = (INC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INC_CNT_W       = $clog2(INC_CYCLES + 1);

	// register indices; byte address is index times four
	localparam logic [3:0] REG_SEC_UNITS   = 4'h0;
	localparam logic [3:0] REG_SEC_TENS    = 4'h1;
	localparam logic [3:0] REG_MIN_TENS    = 4'h3;
	localparam logic [3:0] REG_HOUR_TENS   = 4'h5;
	localparam logic [3:0] REG_DAY_TENS    = 4'h7;
	localparam logic [3:0] REG_MONTH_TENS  = 4'h9;
	localparam logic [3:0] REG_WEEKDAY     = 4'hC;
	localparam logic [3:0] REG_FIRST_CTL   = 4'hD;
	localparam logic [3:0] REG_SECOND_CTL  = 4'hE;
	localparam logic [3:0] REG_THIRD_CTL   = 4'hF;
	localparam int unsigned NUM_CNT_REGS   = 13;
	localparam int unsigned NUM_PAIRS      = 6;

	// bus decode
	localparam int unsigned ADDR_IDX_LSB   = 2;
	localparam int unsigned ADDR_IDX_MSB   = 5;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
	localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

	// control bit positions
	localparam int unsigned FIRST_HOLD_BIT  = 0;
	localparam int unsigned FIRST_BUSY_BIT  = 1;
	localparam int unsigned THIRD_RESET_BIT = 0;
	localparam int unsigned THIRD_STOP_BIT  = 1;

	// used-bit masks
	localparam logic [3:0] MASK_FULL   = 4'hF;
	localparam logic [3:0] MASK_3BIT   = 4'h7;
	localparam logic [3:0] MASK_2BIT   = 4'h3;
	localparam logic [3:0] MASK_1BIT   = 4'h1;
	localparam logic [3:0] MASK_FIRST  = 4'h3;

	// reset values
	localparam logic [3:0] RST_NIBBLE  = 4'h0;

	// bcd limits
	localparam logic [7:0] BCD_00 = 8'h00;
	localparam logic [7:0] BCD_01 = 8'h01;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_28 = 8'h28;
	localparam logic [7:0] BCD_29 = 8'h29;
	localparam logic [7:0] BCD_30 = 8'h30;
	localparam logic [7:0] BCD_31 = 8'h31;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [3:0] BCD_NINE    = 4'h9;
	localparam logic [3:0] WEEKDAY_MAX = 4'h6;

	typedef struct packed {
		logic [3:0] tens;
		logic [3:0] units;
	} rcai_bcd_s;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic       mapped;
		logic [3:0] idx;
	} rcai_acc_s;

	typedef enum logic {
		INC_IDLE,
		INC_RUN
	} rcai_inc_e;

endpackage

// ==== rcai_tick_gen.sv ====
module rcai_tick_gen #(
	parameter int unsigned TICK_CYCLES = rcai_pkg::TICK_CYCLES_DEF
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	// control
	input  wire logic stop,
	input  wire logic clear,
	// one-second event
	output logic      tick
);

	localparam int unsigned W = $clog2(TICK_CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(TICK_CYCLES - 1);

	logic [W-1:0] div_q;

	// the divider freezes while stopped so the sub-second phase is kept
	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			div_q <= '0;
		end else if (!stop) begin
			div_q <= (div_q == LAST) ? '0 : div_q + W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || clear) begin
			tick <= 1'b0;
		end else begin
			tick <= !stop && (div_q == LAST);
		end
	end

endmodule // rcai_tick_gen

// ==== rcai_bcd_pair.sv ====
module rcai_bcd_pair (
	// current value and range
	input  rcai_pkg::rcai_bcd_s cur,
	input  rcai_pkg::rcai_bcd_s lo,
	input  rcai_pkg::rcai_bcd_s hi,
	// next value
	output rcai_pkg::rcai_bcd_s nxt,
	output logic                wrap
);

	// values at or past the top wrap, so a bad host write cannot stick
	always_comb begin
		nxt  = cur;
		wrap = 1'b0;
		if (cur >= hi) begin
			nxt  = lo;
			wrap = 1'b1;
		end else if (cur.units >= rcai_pkg::BCD_NINE) begin
			nxt.tens  = cur.tens + 4'h1;
			nxt.units = 4'h0;
		end else begin
			nxt.units = cur.units + 4'h1;
		end
	end

endmodule // rcai_bcd_pair

// ==== rcai_host_model.sv ====
module rcai_host_model (
	// clock
	input  wire logic        sys_clk,
	// ahb-lite master
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		hsel = 1'h0;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
	end
	// released lines show the inverse, so stale values never pass
	task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= rcai_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge sys_clk);
		while (hready !== 1'h1) @(posedge sys_clk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		haddr <= ~a;
		hwdata <= wd;
		@(posedge sys_clk);
		while (hready !== 1'h1) @(posedge sys_clk);
		rd = hrdata;
		hwdata <= ~wd;
	endtask
	task automatic wr(input logic [3:0] i, input logic [31:0] v);
		logic [31:0] r;
		xfer({26'h0, i, 2'h0}, 1'h1, v, r);
	endtask
	task automatic rd(input logic [3:0] i, output logic [31:0] r);
		xfer({26'h0, i, 2'h0}, 1'h0, 32'h0000_0000, r);
	endtask
	task automatic freeze_on();
		logic [31:0] r;
		wr(rcai_pkg::REG_FIRST_CTL, 32'h0000_0001);
		r = 32'h0000_0002;
		for (int n = 0; n < 64 && r[1] !== 1'h0; n++) rd(rcai_pkg::REG_FIRST_CTL, r);
	endtask
	task automatic freeze_off();
		wr(rcai_pkg::REG_FIRST_CTL, 32'h0000_0000);
	endtask
endmodule // rcai_host_model

// ==== rcai_checker.sv ====
module rcai_checker #(
	parameter int unsigned TICK_CYCLES = 64
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        sys_rst,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] hrdata,
	// status
	input wire logic        counter_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int INC = rcai_pkg::INC_CYCLES;
	logic [3:0] idx;
	logic       rd;
	logic       map;
	logic       wd_q;
	logic       frz_q;
	logic [7:0] run_q;
	assign idx = haddr[5:2];
	assign map = haddr[31:6] == 26'h0 && haddr[1:0] == 2'h0;
	assign rd = hsel && hready && htrans == rcai_pkg::HTRANS_NONSEQ && !hwrite;
	// freeze mirror follows the write data phase
	always_ff @(posedge sys_clk) begin
		if (sys_rst) wd_q <= 1'h0;
		else if (hready) wd_q <= hsel && htrans == rcai_pkg::HTRANS_NONSEQ && hwrite && haddr == 32'h0000_0034;
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) frz_q <= 1'h0;
		else if (wd_q && hready) frz_q <= hwdata[0];
	end
	always_ff @(posedge sys_clk) begin
		if (sys_rst) run_q <= 8'h00;
		else if (frz_q && counter_busy) run_q <= run_q + 8'h01;
		else run_q <= 8'h00;
	end
	function automatic logic [3:0] used(input logic [3:0] i);
		case (i)
			4'h1, 4'h3, 4'h5, 4'hC: used = 4'h7;
			4'h7, 4'hD: used = 4'h3;
			4'h9: used = 4'h1;
			default: used = 4'hF;
		endcase
	endfunction
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	property p_hi;
		hrdata[31:4] == 28'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_unmap;
		rd && !map |=> hrdata == rcai_pkg::RDATA_ZERO;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_unused;
		rd && map |=> (hrdata[3:0] & ~used($past(idx))) == 4'h0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused bit read as one");
	property p_inh;
		rd && map && idx <= rcai_pkg::REG_WEEKDAY && counter_busy |=> hrdata == 32'h0000_0000;
	endproperty
	a_inh: assert property (p_inh) else $error("counter read while busy");
	property p_ctl;
		rd && map && idx == rcai_pkg::REG_FIRST_CTL |=> hrdata[1:0] == {$past(counter_busy), $past(frz_q)};
	endproperty
	a_ctl: assert property (p_ctl) else $error("control read wrong");
	property p_bcd;
		rd && map && !counter_busy && idx < rcai_pkg::REG_WEEKDAY && !idx[0] |=> hrdata[3:0] <= 4'h9;
	endproperty
	a_bcd: assert property (p_bcd) else $error("digit not bcd");
	property p_free;
		!frz_q |-> counter_busy;
	endproperty
	a_free: assert property (p_free) else $error("busy low without freeze");
	property p_len;
		run_q <= INC;
	endproperty
	a_len: assert property (p_len) else $error("busy too long");
endmodule // rcai_checker

bind rcai_top rcai_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .counter_busy(counter_busy)
);

// ==== rcai_testbench.sv ====
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned TICK = 64;
	localparam logic [51:0] LIM  = 52'hA6A6_A3A4_A2AA_7;
	localparam logic [51:0] RIN  = 52'h9595_3213_2199_6;
	localparam logic [51:0] ROUT = 52'h0000_0010_1000_0;
	logic        sys_clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp, counter_busy;
	logic [31:0] haddr, hwdata, hrdata, d, w;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [3:0]  exp [13];
	int          err_total, comparisons, seed;
	assign hready = hreadyout;
	rcai_top #(.TICK_CYCLES(TICK)) uut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .counter_busy(counter_busy)
	);
	rcai_host_model host (
		.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata)
	);
	function automatic logic [3:0] dig(input logic [51:0] v, input int i);
		dig = v[51 - 4 * i -: 4];
	endfunction
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		comparisons++;
		if (seen !== ex) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		#50_000;
		err_total++;
		close_out();
	end
	initial begin
		sys_rst = 1'h1;
		seed = 32'hec80ff58;
		err_total = 0;
		comparisons = 0;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'h0;
		@(posedge sys_clk);
		host.rd(rcai_pkg::REG_FIRST_CTL, d);
		check("ctl after reset", d, 32'h0000_0002);
		host.rd(rcai_pkg::REG_SEC_UNITS, d);
		check("counter at reset", d, 32'h0000_0000);
		// test bit zero; stop and prescaler reset keep ticks out
		host.wr(rcai_pkg::REG_THIRD_CTL, 32'h0000_0003);
		repeat (rcai_pkg::INC_CYCLES + 5) @(posedge sys_clk);
		host.freeze_on();
		// write every counter; upper data bits are random noise
		for (int i = 0; i < 13; i++) begin
			w = $random(seed);
			exp[i] = 4'(w[7:0] % {4'h0, dig(LIM, i)});
			host.wr(4'(i), {w[31:4], exp[i]});
		end
		for (int i = 0; i < 13; i++) begin
			host.rd(4'(i), d);
			check("counter", d, {28'h0, exp[i]});
		end
		host.wr(rcai_pkg::REG_SEC_TENS, 32'hFFFF_FFFF);
		host.rd(rcai_pkg::REG_SEC_TENS, d);
		check("unused bits", d, 32'h0000_0007);
		host.rd(rcai_pkg::REG_FIRST_CTL, d);
		check("ctl frozen idle", d, 32'h0000_0001);
		host.freeze_off();
		host.wr(rcai_pkg::REG_SEC_UNITS, {28'h0, 4'h9 - exp[0]});
		// sec tens holds 7 here, so a leaking read cannot look like zero
		host.rd(rcai_pkg::REG_SEC_TENS, d);
		check("read while busy", d, 32'h0000_0000);
		host.wr(rcai_pkg::REG_SECOND_CTL, 32'h0000_000A);
		host.rd(rcai_pkg::REG_SECOND_CTL, d);
		check("ctl any time", d, 32'h0000_000A);
		host.freeze_on();
		host.rd(rcai_pkg::REG_SEC_UNITS, d);
		check("write inhibited", d, {28'h0, exp[0]});
		host.xfer(32'h0000_0074, 1'h1, 32'h0000_0000, d);
		host.xfer(32'h0000_0035, 1'h0, 32'h0000_0000, d);
		check("unmapped read", d, 32'h0000_0000);
		host.rd(rcai_pkg::REG_FIRST_CTL, d);
		check("unmapped write", d, 32'h0000_0001);
		// last second of a century, then one tick
		for (int i = 0; i < 13; i++) host.wr(4'(i), {28'h0, dig(RIN, i)});
		host.wr(rcai_pkg::REG_THIRD_CTL, 32'h0000_0000);
		host.freeze_off();
		repeat (TICK + rcai_pkg::INC_CYCLES + 10) @(posedge sys_clk);
		host.freeze_on();
		for (int i = 0; i < 13; i++) begin
			host.rd(4'(i), d);
			check("rollover", d, {28'h0, dig(ROUT, i)});
		end
		// a second kept while frozen runs once unfrozen; freeze set mid-increment keeps busy up
		repeat (TICK) @(posedge sys_clk);
		host.freeze_off();
		host.wr(rcai_pkg::REG_FIRST_CTL, 32'h0000_0001);
		host.rd(rcai_pkg::REG_FIRST_CTL, d);
		check("busy in increment", d, 32'h0000_0003);
		host.freeze_on();
		host.rd(rcai_pkg::REG_SEC_UNITS, d);
		check("held second", d, 32'h0000_0001);
		check("response", {30'h0, hreadyout, hresp}, 32'h0000_0002);
		close_out();
	end
endmodule // testbench
